// file: bstap_map.vh
// tap constants: states, instruction codes, id fields, register lengths.
// assumes a single system clock that oversamples the test clock.
`ifndef BSTAP_MAP_VH
`define BSTAP_MAP_VH
`define BSTAP_IR_LEN 10
`define BSTAP_ID_LEN 32
`define BSTAP_ST_RESET 4'h0
`define BSTAP_ST_IDLE 4'h1
`define BSTAP_ST_SEL_DR 4'h2
`define BSTAP_ST_CAP_DR 4'h3
`define BSTAP_ST_SH_DR 4'h4
`define BSTAP_ST_EX1_DR 4'h5
`define BSTAP_ST_PA_DR 4'h6
`define BSTAP_ST_EX2_DR 4'h7
`define BSTAP_ST_UP_DR 4'h8
`define BSTAP_ST_SEL_IR 4'h9
`define BSTAP_ST_CAP_IR 4'ha
`define BSTAP_ST_SH_IR 4'hb
`define BSTAP_ST_EX1_IR 4'hc
`define BSTAP_ST_PA_IR 4'hd
`define BSTAP_ST_EX2_IR 4'he
`define BSTAP_ST_UP_IR 4'hf
`define BSTAP_OP_EXTEST 10'h000
`define BSTAP_OP_SAMPLE 10'h055
`define BSTAP_OP_IDCODE 10'h059
`define BSTAP_OP_ISP_FIRST 10'h200
`define BSTAP_OP_ISP_LAST 10'h2ff
`define BSTAP_OP_BYPASS 10'h3ff
`define BSTAP_IR_CAPTURE 10'h001
`define BSTAP_ID_LSB 1'h1
`define BSTAP_BSR_LEN_DEF 288
`define BSTAP_ISP_LEN_DEF 16
`endif

// file: bstap_bsr.v
// boundary register: capture/shift stage plus update stage.
// assumes shift/capture/update strobes are single sys_clk pulses.
`timescale 1ns/1ps
module bstap_bsr #(
  parameter LEN = 288
) (
  input wire sys_clk,
  input wire nrst,
  input wire cap,
  input wire shift,
  input wire upd,
  input wire si,
  input wire [LEN-1:0] pins_in,
  output wire so,
  output reg [LEN-1:0] upd_ff
);
  reg [LEN-1:0] sh_ff;
  assign so = sh_ff[0];
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sh_ff <= {LEN{1'b0}};
      upd_ff <= {LEN{1'b0}};
    end else begin
      if (cap)
        sh_ff <= pins_in;
      else if (shift)
        sh_ff <= {si, sh_ff[LEN-1:1]};
      if (upd)
        upd_ff <= sh_ff;
    end
  end
endmodule // bstap_bsr

// file: bstap_top.v
// boundary-scan test port controller, oversampled on sys_clk.
// assumes tck, tms, tdi, trst_n come from pins; cfg_jtag_en is a static config level.
`timescale 1ns/1ps
`include "bstap_map.vh"
module bstap_top #(
  parameter HAS_BSR = 1,
  parameter BSR_LEN = `BSTAP_BSR_LEN_DEF,
  parameter ISP_LEN = `BSTAP_ISP_LEN_DEF,
  parameter [3:0] ID_VERSION = 4'h1, // arbitrary
  parameter [15:0] ID_PART = 16'h1234, // arbitrary
  parameter [10:0] ID_MAKER = 11'h0aa // arbitrary
) (
  input wire sys_clk,
  input wire nrst,
  input wire cfg_jtag_en,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo_ff,
  output reg tdo_oe_n_ff,
  output wire user_pins_free,
  input wire [BSR_LEN-1:0] pins_in,
  input wire [BSR_LEN-1:0] core_out,
  output reg [BSR_LEN-1:0] pins_out,
  output wire extest_active,
  output reg [ISP_LEN-1:0] isp_data_ff,
  output reg isp_upd_ff,
  output reg [`BSTAP_IR_LEN-1:0] ir_ff
);
  // two-stage synchronisers; first stage read only by second
  reg [3:0] s1_ff, s2_ff;
  reg tck_d_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      tck_d_ff <= 1'b0;
    end else begin
      s1_ff <= {trst_n, tdi, tms, tck};
      s2_ff <= s1_ff;
      tck_d_ff <= s2_ff[0];
    end
  end
  wire tms_s = s2_ff[1];
  wire tdi_s = s2_ff[2];
  wire trst_s = ~s2_ff[3] | ~cfg_jtag_en;
  wire rise = s2_ff[0] & ~tck_d_ff;
  wire fall = ~s2_ff[0] & tck_d_ff;

  assign user_pins_free = ~cfg_jtag_en;

  function [3:0] nxt_state;
    input [3:0] s;
    input m;
    begin
      case (s)
        `BSTAP_ST_RESET: nxt_state = m ? `BSTAP_ST_RESET : `BSTAP_ST_IDLE;
        `BSTAP_ST_IDLE: nxt_state = m ? `BSTAP_ST_SEL_DR : `BSTAP_ST_IDLE;
        `BSTAP_ST_SEL_DR: nxt_state = m ? `BSTAP_ST_SEL_IR : `BSTAP_ST_CAP_DR;
        `BSTAP_ST_CAP_DR: nxt_state = m ? `BSTAP_ST_EX1_DR : `BSTAP_ST_SH_DR;
        `BSTAP_ST_SH_DR: nxt_state = m ? `BSTAP_ST_EX1_DR : `BSTAP_ST_SH_DR;
        `BSTAP_ST_EX1_DR: nxt_state = m ? `BSTAP_ST_UP_DR : `BSTAP_ST_PA_DR;
        `BSTAP_ST_PA_DR: nxt_state = m ? `BSTAP_ST_EX2_DR : `BSTAP_ST_PA_DR;
        `BSTAP_ST_EX2_DR: nxt_state = m ? `BSTAP_ST_UP_DR : `BSTAP_ST_SH_DR;
        `BSTAP_ST_UP_DR: nxt_state = m ? `BSTAP_ST_SEL_DR : `BSTAP_ST_IDLE;
        `BSTAP_ST_SEL_IR: nxt_state = m ? `BSTAP_ST_RESET : `BSTAP_ST_CAP_IR;
        `BSTAP_ST_CAP_IR: nxt_state = m ? `BSTAP_ST_EX1_IR : `BSTAP_ST_SH_IR;
        `BSTAP_ST_SH_IR: nxt_state = m ? `BSTAP_ST_EX1_IR : `BSTAP_ST_SH_IR;
        `BSTAP_ST_EX1_IR: nxt_state = m ? `BSTAP_ST_UP_IR : `BSTAP_ST_PA_IR;
        `BSTAP_ST_PA_IR: nxt_state = m ? `BSTAP_ST_EX2_IR : `BSTAP_ST_PA_IR;
        `BSTAP_ST_EX2_IR: nxt_state = m ? `BSTAP_ST_UP_IR : `BSTAP_ST_SH_IR;
        `BSTAP_ST_UP_IR: nxt_state = m ? `BSTAP_ST_SEL_DR : `BSTAP_ST_IDLE;
        default: nxt_state = `BSTAP_ST_RESET;
      endcase
    end
  endfunction

  reg [3:0] st_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      st_ff <= `BSTAP_ST_RESET;
    else if (trst_s)
      st_ff <= `BSTAP_ST_RESET;
    else if (rise)
      st_ff <= nxt_state(st_ff, tms_s);
  end

  // capture and shift strobes act on the rising test clock edge leaving the state; update strobes on the falling edge
  wire in_cap_dr = rise & (st_ff == `BSTAP_ST_CAP_DR);
  wire in_sh_dr = rise & (st_ff == `BSTAP_ST_SH_DR);
  wire in_up_dr = fall & (st_ff == `BSTAP_ST_UP_DR);
  wire in_cap_ir = rise & (st_ff == `BSTAP_ST_CAP_IR);
  wire in_sh_ir = rise & (st_ff == `BSTAP_ST_SH_IR);
  wire in_up_ir = fall & (st_ff == `BSTAP_ST_UP_IR);

  // instruction register
  reg [`BSTAP_IR_LEN-1:0] irs_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irs_ff <= {`BSTAP_IR_LEN{1'b0}};
      ir_ff <= `BSTAP_OP_IDCODE;
    end else begin
      if (in_cap_ir)
        irs_ff <= `BSTAP_IR_CAPTURE;
      else if (in_sh_ir)
        irs_ff <= {tdi_s, irs_ff[`BSTAP_IR_LEN-1:1]};
      if (st_ff == `BSTAP_ST_RESET)
        ir_ff <= `BSTAP_OP_IDCODE;
      else if (in_up_ir)
        ir_ff <= irs_ff;
    end
  end

  wire op_bnd = (ir_ff == `BSTAP_OP_EXTEST) | (ir_ff == `BSTAP_OP_SAMPLE);
  wire sel_bsr = op_bnd & (HAS_BSR != 0);
  wire sel_id = (ir_ff == `BSTAP_OP_IDCODE);
  wire sel_isp = (ir_ff >= `BSTAP_OP_ISP_FIRST) & (ir_ff <= `BSTAP_OP_ISP_LAST);
  wire sel_byp = ~sel_bsr & ~sel_id & ~sel_isp;
  assign extest_active = (ir_ff == `BSTAP_OP_EXTEST) & (HAS_BSR != 0);

  // bypass, identification and programming data registers
  reg byp_ff;
  reg [`BSTAP_ID_LEN-1:0] id_ff;
  reg [ISP_LEN-1:0] isp_sh_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      byp_ff <= 1'b0;
      id_ff <= {`BSTAP_ID_LEN{1'b0}};
      isp_sh_ff <= {ISP_LEN{1'b0}};
      isp_data_ff <= {ISP_LEN{1'b0}};
      isp_upd_ff <= 1'b0;
    end else begin
      isp_upd_ff <= in_up_dr & sel_isp;
      if (in_cap_dr) begin
        byp_ff <= 1'b0;
        id_ff <= {ID_VERSION, ID_PART, ID_MAKER, `BSTAP_ID_LSB};
        isp_sh_ff <= isp_data_ff;
      end else if (in_sh_dr) begin
        byp_ff <= tdi_s;
        id_ff <= {tdi_s, id_ff[`BSTAP_ID_LEN-1:1]};
        isp_sh_ff <= {tdi_s, isp_sh_ff[ISP_LEN-1:1]};
      end
      if (in_up_dr & sel_isp)
        isp_data_ff <= isp_sh_ff;
    end
  end

  wire bsr_so;
  wire [BSR_LEN-1:0] bsr_upd;
  bstap_bsr #(.LEN(BSR_LEN)) u_bsr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cap(in_cap_dr & sel_bsr),
    .shift(in_sh_dr & sel_bsr),
    .upd(in_up_dr & sel_bsr),
    .si(tdi_s),
    .pins_in(pins_in),
    .so(bsr_so),
    .upd_ff(bsr_upd)
  );

  // pins follow core unless extest forces the update stage
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      pins_out <= {BSR_LEN{1'b0}};
    else
      pins_out <= extest_active ? bsr_upd : core_out;
  end

  // tdo changes on the falling test clock edge
  reg nxt_tdo;
  always @* begin
    if (st_ff == `BSTAP_ST_SH_IR)
      nxt_tdo = irs_ff[0];
    else if (sel_bsr)
      nxt_tdo = bsr_so;
    else if (sel_id)
      nxt_tdo = id_ff[0];
    else if (sel_isp)
      nxt_tdo = isp_sh_ff[0];
    else
      nxt_tdo = byp_ff;
  end
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tdo_ff <= 1'b0;
      tdo_oe_n_ff <= 1'b1;
    end else if (trst_s) begin
      // test reset or disabled port must never leave tdo driven
      tdo_oe_n_ff <= 1'b1;
    end else if (fall) begin
      tdo_ff <= nxt_tdo;
      tdo_oe_n_ff <= ~((st_ff == `BSTAP_ST_SH_DR) | (st_ff == `BSTAP_ST_SH_IR));
    end
  end
endmodule // bstap_top

// file: bstap_top_monitor.sv
// assertions on the test port outputs.
// assumes it is bound into bstap_top.
`timescale 1ns/1ps
`include "bstap_map.vh"
module bstap_monitor #(
  parameter HAS_BSR = 1,
  parameter BSR_LEN = 288
) (
  input wire sys_clk,
  input wire nrst,
  input wire cfg_jtag_en,
  input wire tck,
  input wire tdo_ff,
  input wire tdo_oe_n_ff,
  input wire user_pins_free,
  input wire [BSR_LEN-1:0] core_out,
  input wire [BSR_LEN-1:0] pins_out,
  input wire extest_active,
  input wire isp_upd_ff,
  input wire [`BSTAP_IR_LEN-1:0] ir_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // six cycles covers the input sync
  sequence s_off;
    !cfg_jtag_en [*6];
  endsequence
  a_pins_free: assert property (user_pins_free == !cfg_jtag_en) else $error("bad release");
  a_oe_off: assert property (s_off |-> tdo_oe_n_ff) else $error("tdo driven when off");
  a_ir_reset: assert property (s_off |-> ir_ff == `BSTAP_OP_IDCODE) else $error("ir not id");
  a_extest_flag: assert property (extest_active == (HAS_BSR != 0 && ir_ff == `BSTAP_OP_EXTEST))
    else $error("bad extest flag");
  a_pins_core: assert property (!extest_active |=> pins_out == $past(core_out)) else $error("core blocked");
  a_isp_pulse: assert property (isp_upd_ff |=> !isp_upd_ff) else $error("long update");
  a_isp_op: assert property (isp_upd_ff |-> ir_ff[9:8] == 2'h2) else $error("update off isp");
  a_tdo_fall: assert property ($changed(tdo_ff) |-> !tck) else $error("tdo moved, tck high");
endmodule // bstap_monitor
bind bstap_top bstap_monitor #(.HAS_BSR(HAS_BSR), .BSR_LEN(BSR_LEN)) mon (.sys_clk, .nrst, .cfg_jtag_en,
  .tck, .tdo_ff, .tdo_oe_n_ff, .user_pins_free, .core_out, .pins_out, .extest_active, .isp_upd_ff, .ir_ff);

// file: bstap_ctl.sv
// model of the external scan controller.
// assumes sys_clk runs eight times the test clock.
`timescale 1ns/1ps
module bstap_ctl (
  input wire sys_clk,
  input wire tdo,
  output logic tck = 1'h0,
  output logic tms = 1'h1,
  output logic tdi = 1'h0
);
  // tck stands low between scans
  task step(input logic m, input logic d, output logic v);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    v = tdo;
    @(posedge sys_clk);
    tck <= 1'h1;
    repeat (4) @(posedge sys_clk);
    tck <= 1'h0;
  endtask
  // idle to idle; tdi toggles outside shifting
  task scan(input logic ir, input int n, input logic [511:0] din, output logic [511:0] dout);
    logic v;
    dout = '0;
    step(1'h1, ~tdi, v);
    if (ir) step(1'h1, ~tdi, v);
    step(1'h0, ~tdi, v);
    step(1'h0, ~tdi, v);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], v);
      dout[i] = v;
    end
    step(1'h1, ~tdi, v);
    step(1'h0, ~tdi, v);
  endtask
endmodule // bstap_ctl

// file: bstap_top_tb.sv
// self-checking bench for the test port.
// assumes bstap_ctl plays the external controller.
`timescale 1ns/1ps
`include "bstap_map.vh"
module bstap_top_tb;
  localparam int BL = 288;
  localparam int IL = 16;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic cfg_jtag_en = 1'h1;
  logic trst_n = 1'h1;
  logic [BL-1:0] pins_in = '0;
  logic [BL-1:0] core_out = '0;
  wire tck, tms, tdi, tdo_ff, tdo_oe_n_ff, user_pins_free, extest_active, isp_upd_ff;
  wire [BL-1:0] pins_out;
  wire [IL-1:0] isp_data_ff;
  wire [9:0] ir_ff;
  wire tdo_pin = tdo_oe_n_ff ? sys_clk : tdo_ff; // released line toggles
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] rs = 32'h000062fa;
  logic [511:0] pat, dout;
  logic q;
  // id field values are arbitrary
  bstap_top #(.BSR_LEN(BL), .ISP_LEN(IL), .ID_VERSION(4'h3), .ID_PART(16'h5a5a), .ID_MAKER(11'h123)) DUT (
    .sys_clk, .nrst, .cfg_jtag_en, .tck, .tms, .tdi, .trst_n, .tdo_ff, .tdo_oe_n_ff, .user_pins_free,
    .pins_in, .core_out, .pins_out, .extest_active, .isp_data_ff, .isp_upd_ff, .ir_ff);
  bstap_ctl ctl (.sys_clk, .tdo(tdo_pin), .tck, .tms, .tdi);
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function logic [31:0] exp_id();
    return {4'h3, 16'h5a5a, 11'h123, 1'h1};
  endfunction
  task chk(input logic [511:0] seen, input logic [511:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task fill();
    for (int k = 0; k < 16; k++) begin
      pat[k*32+:32] = rnd();
      if (k < 9) pins_in[k*32+:32] <= rnd();
      if (k < 9) core_out[k*32+:32] <= rnd();
    end
  endtask
  task ld(input logic [9:0] op);
    ctl.scan(1'h1, 10, op, dout);
    chk(dout[9:0], `BSTAP_IR_CAPTURE);
    chk(ir_ff, op);
  endtask
  task results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 sys_clk = ~sys_clk;
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'h1;
    ctl.step(1'h0, 1'h0, q);
    fill();
    ctl.scan(1'h0, 32, pat, dout);
    chk(dout[31:0], exp_id());
    ld(`BSTAP_OP_BYPASS);
    ctl.scan(1'h0, 16, pat, dout);
    chk(dout[15:0], {pat[14:0], 1'h0});
    ld(`BSTAP_OP_SAMPLE);
    chk(pins_out, core_out);
    ctl.scan(1'h0, BL + 8, pat, dout);
    chk(dout[BL-1:0], pins_in);
    chk(dout[BL+7:BL], pat[7:0]);
    ld(`BSTAP_OP_EXTEST);
    chk({extest_active, pins_out}, {1'h1, pat[BL+7:8]});
    fill();
    ctl.scan(1'h0, BL, pat, dout);
    chk(dout[BL-1:0], pins_in);
    chk(pins_out, pat[BL-1:0]);
    ld(`BSTAP_OP_ISP_LAST);
    ld(`BSTAP_OP_ISP_FIRST);
    ctl.scan(1'h0, IL, pat, dout);
    chk(isp_data_ff, pat[IL-1:0]);
    ld(`BSTAP_OP_IDCODE);
    ctl.scan(1'h0, 32, pat, dout);
    chk(dout[31:0], exp_id());
    ld(`BSTAP_OP_BYPASS);
    trst_n <= 1'h0;
    repeat (6) @(posedge sys_clk);
    trst_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk({tdo_oe_n_ff, ir_ff}, {1'h1, `BSTAP_OP_IDCODE});
    ctl.step(1'h0, 1'h0, q);
    ctl.scan(1'h0, 32, pat, dout);
    chk(dout[31:0], exp_id());
    cfg_jtag_en <= 1'h0;
    repeat (10) @(posedge sys_clk);
    chk({user_pins_free, tdo_oe_n_ff, ir_ff}, {2'h3, `BSTAP_OP_IDCODE});
    results();
  end
  // whole run needs about 6900 cycles
  initial begin
    #2000000;
    err_count++;
    results();
  end
endmodule // bstap_top_tb
